// >>> logic/adcc_pkg.sv
package adcc_pkg;

  // clock and timing
  localparam int CLK_MHZ          = 125;
  localparam int EXT_DELAY_US     = 400;
  localparam int EXT_DELAY_CYC    = EXT_DELAY_US * CLK_MHZ;
  localparam int BASE_DELAY_NS    = 800;
  localparam int BASE_DELAY_CYC   = (BASE_DELAY_NS * CLK_MHZ + 999) / 1000;
  localparam int TMR_W            = 20;
  localparam int PERIOD_UNIT_CYC  = 1024;
  localparam int PER_CNT_W        = 18;

  // register bus
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  localparam logic [ADDR_W-1:0] OFS_CTRL      = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_SW_SELECT = 8'h01;
  localparam logic [ADDR_W-1:0] OFS_SW_RES_LO = 8'h02;
  localparam logic [ADDR_W-1:0] OFS_SW_RES_HI = 8'h03;
  localparam logic [ADDR_W-1:0] OFS_AUTO_SEL  = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_AUTO_CTRL = 8'h05;
  localparam logic [ADDR_W-1:0] OFS_AUTO_PER  = 8'h06;
  localparam logic [ADDR_W-1:0] OFS_AUTO0_LO  = 8'h07;
  localparam logic [ADDR_W-1:0] OFS_AUTO0_HI  = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_AUTO1_LO  = 8'h09;
  localparam logic [ADDR_W-1:0] OFS_AUTO1_HI  = 8'h0A;
  localparam logic [ADDR_W-1:0] OFS_STATUS    = 8'h0B;

  // field positions
  localparam int CTRL_FORCE_BIT  = 0;
  localparam int CTRL_EXTEND_BIT = 1;
  localparam int CTRL_ISRC_LSB   = 2;
  localparam int SW_START_BIT    = 7;
  localparam int AUTO_CH1_LSB    = 4;
  localparam int ST_BUSY_BIT     = 0;
  localparam int ST_SWPEND_BIT   = 1;
  localparam int ST_FIRST_BIT    = 2;
  localparam int ST_BADCH_BIT    = 3;

  // result code
  localparam int RES_W = 12;
  localparam int RES_HI_W = RES_W - DATA_W;

  // channel map
  localparam int CH_W = 4;
  localparam logic [CH_W-1:0] CH_EXT_ZERO = 4'h0;
  localparam logic [CH_W-1:0] CH_EXT_ONE  = 4'h1;
  localparam logic [CH_W-1:0] CH_EXT_TWO  = 4'h2;
  localparam logic [CH_W-1:0] CH_SUPPLY   = 4'h7;
  localparam logic [CH_W-1:0] CH_USB_BUS  = 4'hA;
  localparam logic [CH_W-1:0] CH_CUR_PROB = 4'hB;
  localparam logic [CH_W-1:0] CH_DIE_T0   = 4'hC;
  localparam logic [CH_W-1:0] CH_DIE_T1   = 4'hD;
  localparam logic [CH_W-1:0] CH_TEST_NET = 4'hF;

  typedef enum logic [1:0] {
    ISRC_OFF  = 2'b00,
    ISRC_5UA  = 2'b01,
    ISRC_15UA = 2'b10,
    ISRC_20UA = 2'b11
  } adcc_isrc_e;

  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_SETTLE  = 2'b01,
    ST_CONVERT = 2'b10
  } adcc_state_e;

  function automatic logic chan_valid(input logic [CH_W-1:0] ch);
    chan_valid = (ch == CH_EXT_ZERO) || (ch == CH_EXT_ONE) || (ch == CH_EXT_TWO) ||
                 (ch == CH_SUPPLY) || (ch == CH_USB_BUS) || (ch == CH_CUR_PROB) ||
                 (ch == CH_DIE_T0) || (ch == CH_DIE_T1) || (ch == CH_TEST_NET);
  endfunction

endpackage

// >>> logic/adcc_delay_timer.sv
`timescale 1ns/1ps
module adcc_delay_timer
  import adcc_pkg::*;
(
  // clock and reset
  input  wire logic             clk_in,
  input  wire logic             nrst_in,
  // control
  input  wire logic             start_in,
  input  wire logic [TMR_W-1:0] load_in,
  // status
  output logic                  done_out
);

  logic [TMR_W-1:0] cnt_q;
  logic             run_q;

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      cnt_q <= '0;
      run_q <= 1'b0;
    end
    else if (start_in)
    begin
      cnt_q <= load_in;
      run_q <= 1'b1;
    end
    else if (run_q)
    begin
      cnt_q <= cnt_q - 1'b1;
      if (cnt_q == TMR_W'(1))
        run_q <= 1'b0;
    end
  end

  // one-cycle pulse in the last cycle of the count
  assign done_out = run_q && (cnt_q == TMR_W'(1));

endmodule

// >>> logic/adcc_conv_ctrl.sv
// The implementer's own choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
module adcc_conv_ctrl
  import adcc_pkg::*;
#(
  parameter int EXT_DELAY_CYCLES = EXT_DELAY_CYC
)
(
  // clock and reset
  input  wire logic              CLK_IN,
  input  wire logic              NRST_IN,
  // register port
  input  wire logic [ADDR_W-1:0] REG_ADDR_IN,
  input  wire logic [DATA_W-1:0] REG_WDATA_IN,
  input  wire logic              REG_WR_IN,
  input  wire logic              REG_RD_IN,
  output logic      [DATA_W-1:0] REG_RDATA_OUT,
  // converter core
  input  wire logic              ADC_DONE_IN,
  input  wire logic [RES_W-1:0]  ADC_DATA_IN,
  output logic                   ADC_EN_OUT,
  output logic                   ADC_VREF_EN_OUT,
  output logic      [CH_W-1:0]   ADC_CHAN_OUT,
  output logic      [1:0]        ADC_ISRC_OUT,
  output logic                   ADC_SAMPLE_OUT,
  // events
  output logic                   CONV_IRQ_OUT,
  output logic                   AUTO_DONE_OUT
);

  adcc_state_e      state_q;
  adcc_state_e      state_d;

  logic             force_q;
  logic             extend_q;
  adcc_isrc_e       isrc_q;
  logic [CH_W-1:0]  sw_chan_q;
  logic             sw_pend_q;
  logic [CH_W-1:0]  auto_ch0_q;
  logic [CH_W-1:0]  auto_ch1_q;
  logic [1:0]       auto_en_q;
  logic [DATA_W-1:0] auto_per_q;
  logic [1:0]       auto_pend_q;
  logic             round_idx_q;
  logic [PER_CNT_W-1:0] per_cnt_q;
  logic             first_q;
  logic             badch_q;

  logic [RES_W-1:0] sw_res_q;
  logic [RES_W-1:0] auto_res0_q;
  logic [RES_W-1:0] auto_res1_q;

  logic             act_sw_q;
  logic [CH_W-1:0]  act_chan_q;
  logic             sample_q;
  logic             irq_q;
  logic             auto_done_q;
  logic [DATA_W-1:0] rdata_q;

  logic             done_s1_q;
  logic             done_s2_q;
  logic             done_s3_q;
  logic [RES_W-1:0] data_s1_q;
  logic [RES_W-1:0] data_s2_q;

  logic             wr_ctrl;
  logic             wr_sw;
  logic             wr_asel;
  logic             wr_actl;
  logic             wr_aper;
  logic             wr_stat;
  logic             sw_req;
  logic             tick;
  logic             start_sw;
  logic             start_auto;
  logic             pick_slot1;
  logic             tmr_start;
  logic             tmr_done;
  logic             done_edge;
  logic             conv_end;
  logic [TMR_W-1:0] tmr_load;

  assign wr_ctrl = REG_WR_IN && (REG_ADDR_IN == OFS_CTRL);
  assign wr_sw   = REG_WR_IN && (REG_ADDR_IN == OFS_SW_SELECT);
  assign wr_asel = REG_WR_IN && (REG_ADDR_IN == OFS_AUTO_SEL);
  assign wr_actl = REG_WR_IN && (REG_ADDR_IN == OFS_AUTO_CTRL);
  assign wr_aper = REG_WR_IN && (REG_ADDR_IN == OFS_AUTO_PER);
  assign wr_stat = REG_WR_IN && (REG_ADDR_IN == OFS_STATUS);

  assign sw_req = wr_sw && REG_WDATA_IN[SW_START_BIT];

  // converter pins are asynchronous to this clock
  always_ff @(posedge CLK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
    begin
      done_s1_q <= 1'b0;
      done_s2_q <= 1'b0;
      done_s3_q <= 1'b0;
      data_s1_q <= '0;
      data_s2_q <= '0;
    end
    else
    begin
      done_s1_q <= ADC_DONE_IN;
      done_s2_q <= done_s1_q;
      done_s3_q <= done_s2_q;
      data_s1_q <= ADC_DATA_IN;
      data_s2_q <= data_s1_q;
    end
  end

  assign done_edge = done_s2_q && !done_s3_q;
  assign conv_end  = (state_q == ST_CONVERT) && done_edge;

  // control register
  always_ff @(posedge CLK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
    begin
      force_q  <= 1'b0;
      extend_q <= 1'b0;
      isrc_q   <= ISRC_OFF;
    end
    else if (wr_ctrl)
    begin
      force_q  <= REG_WDATA_IN[CTRL_FORCE_BIT];
      extend_q <= REG_WDATA_IN[CTRL_EXTEND_BIT];
      isrc_q   <= adcc_isrc_e'(REG_WDATA_IN[CTRL_ISRC_LSB +: 2]);
    end
  end

  // periodic configuration
  always_ff @(posedge CLK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
    begin
      auto_ch0_q <= '0;
      auto_ch1_q <= '0;
      auto_en_q  <= '0;
      auto_per_q <= '0;
    end
    else
    begin
      if (wr_asel)
      begin
        auto_ch0_q <= REG_WDATA_IN[CH_W-1:0];
        auto_ch1_q <= REG_WDATA_IN[AUTO_CH1_LSB +: CH_W];
      end
      if (wr_actl)
        auto_en_q <= REG_WDATA_IN[1:0];
      if (wr_aper)
        auto_per_q <= REG_WDATA_IN;
    end
  end

  // period counter; a period of zero stops the periodic requests
  always_ff @(posedge CLK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
      per_cnt_q <= '0;
    else if (tick || (auto_per_q == '0))
      per_cnt_q <= '0;
    else
      per_cnt_q <= per_cnt_q + 1'b1;
  end

  assign tick = (auto_per_q != '0) &&
                (per_cnt_q == PER_CNT_W'(int'(auto_per_q) * PERIOD_UNIT_CYC - 1));

  // software request; a new request in the start cycle is kept
  always_ff @(posedge CLK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
    begin
      sw_chan_q <= '0;
      sw_pend_q <= 1'b0;
    end
    else
    begin
      if (wr_sw)
        sw_chan_q <= REG_WDATA_IN[CH_W-1:0];
      if (sw_req && chan_valid(REG_WDATA_IN[CH_W-1:0]))
        sw_pend_q <= 1'b1;
      else if (start_sw)
        sw_pend_q <= 1'b0;
    end
  end

  // unusable channel flag, set beats clear
  always_ff @(posedge CLK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
      badch_q <= 1'b0;
    else if (sw_req && !chan_valid(REG_WDATA_IN[CH_W-1:0]))
      badch_q <= 1'b1;
    else if (wr_stat && REG_WDATA_IN[ST_BADCH_BIT])
      badch_q <= 1'b0;
  end

  assign start_sw   = (state_q == ST_IDLE) && sw_pend_q;
  assign start_auto = (state_q == ST_IDLE) && !sw_pend_q && (auto_pend_q != 2'b00);

  assign pick_slot1 = auto_pend_q[1] && (!auto_pend_q[0] || (auto_ch1_q < auto_ch0_q));

  // periodic queue; slots with unusable channels are skipped
  always_ff @(posedge CLK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
    begin
      auto_pend_q <= 2'b00;
      round_idx_q <= 1'b0;
    end
    else if (tick)
    begin
      auto_pend_q <= auto_en_q & {chan_valid(auto_ch1_q), chan_valid(auto_ch0_q)};
      round_idx_q <= 1'b0;
    end
    else
    begin
      if (start_auto)
        auto_pend_q[pick_slot1] <= 1'b0;
      if (conv_end && !act_sw_q)
        round_idx_q <= 1'b1;
    end
  end

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE:
        if (start_sw || start_auto)
          state_d = ST_SETTLE;
      ST_SETTLE:
        if (tmr_done)
          state_d = ST_CONVERT;
      ST_CONVERT:
        if (done_edge)
          state_d = ST_IDLE;
      default:
        state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
      state_q <= ST_IDLE;
    else
      state_q <= state_d;
  end

  // active conversion
  always_ff @(posedge CLK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
    begin
      act_sw_q   <= 1'b0;
      act_chan_q <= '0;
    end
    else if (start_sw)
    begin
      act_sw_q   <= 1'b1;
      act_chan_q <= sw_chan_q;
    end
    else if (start_auto)
    begin
      act_sw_q   <= 1'b0;
      act_chan_q <= pick_slot1 ? auto_ch1_q : auto_ch0_q;
    end
  end

  assign tmr_load  = extend_q ? TMR_W'(BASE_DELAY_CYC + EXT_DELAY_CYCLES) : TMR_W'(BASE_DELAY_CYC);
  assign tmr_start = start_sw || start_auto;

  adcc_delay_timer u_settle
  (
    .clk_in   (CLK_IN),
    .nrst_in  (NRST_IN),
    .start_in (tmr_start),
    .load_in  (tmr_load),
    .done_out (tmr_done)
  );

  // results and event pulses
  always_ff @(posedge CLK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
    begin
      sw_res_q    <= '0;
      auto_res0_q <= '0;
      auto_res1_q <= '0;
      irq_q       <= 1'b0;
      auto_done_q <= 1'b0;
      first_q     <= 1'b1;
      sample_q    <= 1'b0;
    end
    else
    begin
      sample_q    <= (state_q == ST_SETTLE) && tmr_done;
      irq_q       <= conv_end && act_sw_q;
      auto_done_q <= conv_end && !act_sw_q;
      if (conv_end)
      begin
        if (act_sw_q)
        begin
          sw_res_q <= data_s2_q;
          first_q  <= 1'b0;
        end
        else if (!round_idx_q)
          auto_res0_q <= data_s2_q;
        else
          auto_res1_q <= data_s2_q;
      end
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge CLK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
      rdata_q <= '0;
    else if (!REG_RD_IN)
      rdata_q <= '0;
    else
    begin
      unique case (REG_ADDR_IN)
        OFS_CTRL:      rdata_q <= DATA_W'({isrc_q, extend_q, force_q});
        OFS_SW_SELECT: rdata_q <= DATA_W'({sw_pend_q, 3'h0, sw_chan_q});
        OFS_SW_RES_LO: rdata_q <= sw_res_q[DATA_W-1:0];
        OFS_SW_RES_HI: rdata_q <= DATA_W'(sw_res_q[RES_W-1:DATA_W]);
        OFS_AUTO_SEL:  rdata_q <= {auto_ch1_q, auto_ch0_q};
        OFS_AUTO_CTRL: rdata_q <= DATA_W'(auto_en_q);
        OFS_AUTO_PER:  rdata_q <= auto_per_q;
        OFS_AUTO0_LO:  rdata_q <= auto_res0_q[DATA_W-1:0];
        OFS_AUTO0_HI:  rdata_q <= DATA_W'(auto_res0_q[RES_W-1:DATA_W]);
        OFS_AUTO1_LO:  rdata_q <= auto_res1_q[DATA_W-1:0];
        OFS_AUTO1_HI:  rdata_q <= DATA_W'(auto_res1_q[RES_W-1:DATA_W]);
        OFS_STATUS:    rdata_q <= DATA_W'({badch_q, first_q, sw_pend_q, state_q != ST_IDLE});
        default:       rdata_q <= '0;
      endcase
    end
  end

  assign REG_RDATA_OUT   = rdata_q;
  assign ADC_EN_OUT      = force_q || (state_q != ST_IDLE);
  assign ADC_VREF_EN_OUT = ADC_EN_OUT;
  assign ADC_CHAN_OUT    = act_chan_q;
  assign ADC_ISRC_OUT    = (ADC_EN_OUT && act_chan_q == CH_EXT_ZERO) ? isrc_q : ISRC_OFF;
  assign ADC_SAMPLE_OUT  = sample_q;
  assign CONV_IRQ_OUT    = irq_q;
  assign AUTO_DONE_OUT   = auto_done_q;

endmodule

// >>> testbench/adcc_core_model.sv
`timescale 1ns/1ps
module adcc_core_model
  import adcc_pkg::*;
(
  // clock and control
  input  wire logic             clk_in,
  input  wire logic             sample_in,
  input  wire logic [CH_W-1:0]  chan_in,
  input  wire logic [RES_W-1:0] base_in,
  input  wire logic [4:0]       lat_in,
  // result
  output logic                  done_out,
  output logic      [RES_W-1:0] data_out
);
  int cnt = 0;
  initial done_out = 1'b0;
  initial data_out = 12'h000;
  // unsigned 12-bit code
  // data settles a cycle before done and is held until the next sample
  always @(posedge clk_in)
  begin
    if (sample_in)
      cnt <= int'(lat_in) + 2;
    else if (cnt > 0)
      cnt <= cnt - 1;
    if (cnt == 2)
      data_out <= base_in ^ {3{chan_in}};
    done_out <= (cnt == 1);
  end
endmodule

// >>> testbench/adcc_conv_ctrl_assertions.sv
`timescale 1ns/1ps
module adcc_chk
  import adcc_pkg::*;
(
  // clock and reset
  input wire logic              CLK_IN,
  input wire logic              NRST_IN,
  // register port
  input wire logic [ADDR_W-1:0] REG_ADDR_IN,
  input wire logic [DATA_W-1:0] REG_WDATA_IN,
  input wire logic              REG_WR_IN,
  input wire logic              REG_RD_IN,
  input wire logic [DATA_W-1:0] REG_RDATA_OUT,
  // converter core
  input wire logic              ADC_DONE_IN,
  input wire logic [RES_W-1:0]  ADC_DATA_IN,
  input wire logic              ADC_EN_OUT,
  input wire logic              ADC_VREF_EN_OUT,
  input wire logic [CH_W-1:0]   ADC_CHAN_OUT,
  input wire logic [1:0]        ADC_ISRC_OUT,
  input wire logic              ADC_SAMPLE_OUT,
  // events
  input wire logic              CONV_IRQ_OUT,
  input wire logic              AUTO_DONE_OUT
);
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (!NRST_IN);
  sequence s_start;
    $rose(ADC_EN_OUT);
  endsequence
  // settle alone is 100 cycles, so eight quiet cycles is a safe floor
  sequence s_quiet;
    !ADC_SAMPLE_OUT [*8];
  endsequence
  a_vref_follows: assert property (ADC_VREF_EN_OUT == ADC_EN_OUT)
    else $error("reference enable differs from converter enable");
  a_isrc_gate: assert property (ADC_ISRC_OUT != 2'b00 |-> ADC_EN_OUT && ADC_CHAN_OUT == CH_EXT_ZERO)
    else $error("bias source on outside input zero");
  a_rdata_idle: assert property (!$past(REG_RD_IN) |-> REG_RDATA_OUT == 8'h00)
    else $error("read data without read");
  a_irq_single: assert property (CONV_IRQ_OUT |=> !CONV_IRQ_OUT)
    else $error("software done longer than a cycle");
  a_auto_single: assert property (AUTO_DONE_OUT |=> !AUTO_DONE_OUT)
    else $error("periodic done longer than a cycle");
  a_sample_busy: assert property (ADC_SAMPLE_OUT |-> ADC_EN_OUT ##1 !ADC_SAMPLE_OUT)
    else $error("sample pulse bad");
  a_settle_quiet: assert property (s_start |-> s_quiet)
    else $error("sample too soon after start");
  a_chan_held: assert property (ADC_SAMPLE_OUT |-> $stable(ADC_CHAN_OUT))
    else $error("channel moved at sample");
  a_done_apart: assert property (CONV_IRQ_OUT |-> !AUTO_DONE_OUT)
    else $error("two completions at once");
  // completion pulses only follow a cycle in which the converter was running
  a_irq_at_end: assert property (CONV_IRQ_OUT |-> $past(ADC_EN_OUT) && !ADC_SAMPLE_OUT)
    else $error("software done without a conversion");
  a_auto_at_end: assert property (AUTO_DONE_OUT |-> $past(ADC_EN_OUT) && !ADC_SAMPLE_OUT)
    else $error("periodic done without a conversion");
endmodule
bind adcc_conv_ctrl adcc_chk chk_u (.CLK_IN(CLK_IN), .NRST_IN(NRST_IN), .REG_ADDR_IN(REG_ADDR_IN),
  .REG_WDATA_IN(REG_WDATA_IN), .REG_WR_IN(REG_WR_IN), .REG_RD_IN(REG_RD_IN), .REG_RDATA_OUT(REG_RDATA_OUT),
  .ADC_DONE_IN(ADC_DONE_IN), .ADC_DATA_IN(ADC_DATA_IN), .ADC_EN_OUT(ADC_EN_OUT),
  .ADC_VREF_EN_OUT(ADC_VREF_EN_OUT), .ADC_CHAN_OUT(ADC_CHAN_OUT), .ADC_ISRC_OUT(ADC_ISRC_OUT),
  .ADC_SAMPLE_OUT(ADC_SAMPLE_OUT), .CONV_IRQ_OUT(CONV_IRQ_OUT), .AUTO_DONE_OUT(AUTO_DONE_OUT));

// >>> testbench/tb.sv
`timescale 1ns/1ps
module tb;
  import adcc_pkg::*;
  // short extension keeps the run brief
  localparam int EXT = 20;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [7:0]  wdata = 8'h00;
  logic [11:0] base = 12'h000;
  logic [4:0]  lat = 5'h04;
  logic [31:0] lfsr = 32'h2C1E9C6F;
  logic [7:0]  rdata, lo, hi;
  logic [11:0] data;
  logic [3:0]  chan;
  logic [1:0]  isrc;
  logic        done, en, vref, samp, irq, adone;
  logic [3:0]  chq[$];
  int          failures = 0;
  int          check_count = 0;
  int          n_set, settle, n0;
  logic        found;

  adcc_conv_ctrl #(.EXT_DELAY_CYCLES(EXT)) dut_u (.CLK_IN(clk), .NRST_IN(nrst), .REG_ADDR_IN(addr),
    .REG_WDATA_IN(wdata), .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata), .ADC_DONE_IN(done),
    .ADC_DATA_IN(data), .ADC_EN_OUT(en), .ADC_VREF_EN_OUT(vref), .ADC_CHAN_OUT(chan), .ADC_ISRC_OUT(isrc),
    .ADC_SAMPLE_OUT(samp), .CONV_IRQ_OUT(irq), .AUTO_DONE_OUT(adone));
  adcc_core_model core_u (.clk_in(clk), .sample_in(samp), .chan_in(chan), .base_in(base), .lat_in(lat),
    .done_out(done), .data_out(data));

  initial
  begin
    forever #4 clk = ~clk;
  end
  always @(posedge clk)
  begin
    if (samp)
      chq.push_back(chan);
  end

  function automatic logic [31:0] nxt();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction
  function automatic logic [15:0] code_of(input logic [3:0] ch);
    return {4'h0, base ^ {3{ch}}};
  endfunction
  function automatic bit ch_ok(input logic [3:0] ch);
    return ch inside {4'h0, 4'h1, 4'h2, 4'h7, 4'hA, 4'hB, 4'hC, 4'hD, 4'hF};
  endfunction

  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    check_count++;
    if (s !== e)
    begin
      failures++;
      $display("FAIL %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  // w: 0 software done, 1 periodic done, 2 sample pulse
  task automatic wait_sig(input int w, input int lim);
    found = 1'b0;
    n_set = 0;
    while (!found && n_set < lim)
    begin
      @(posedge clk);
      #1;
      n_set++;
      found = (w == 0) ? irq : (w == 1) ? adone : samp;
    end
  endtask
  task automatic sw_conv(input logic [3:0] ch, input logic [1:0] iv, input logic ext, input logic [11:0] b);
    base = b;
    lat = 5'(nxt() % 16);
    wr_reg(OFS_CTRL, {4'h0, iv, ext, 1'b0});
    wr_reg(OFS_SW_SELECT, {4'h8, ch});
    wait_sig(2, 400);
    settle = n_set;
    if (!ch_ok(ch))
    begin
      chk("sample", found, 0);
      rd_reg(OFS_STATUS, lo);
      chk("badch", lo[3], 1);
      wr_reg(OFS_STATUS, 8'h08);
      rd_reg(OFS_STATUS, lo);
      chk("badclr", lo[3], 0);
    end
    else
    begin
      chk("chan", chan, ch);
      chk("isrc", isrc, (ch == 4'h0) ? iv : 2'b00);
      wait_sig(0, 400);
      chk("irq", found, 1);
      rd_reg(OFS_SW_RES_LO, lo);
      rd_reg(OFS_SW_RES_HI, hi);
      chk("result", {hi, lo}, code_of(ch));
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    repeat (60000) @(posedge clk);
    failures++;
    give_verdict();
  end

  initial
  begin
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    rd_reg(OFS_STATUS, lo);
    chk("status", lo, 8'h04);
    rd_reg(8'hFF, lo);
    chk("unmapped", lo, 8'h00);
    wr_reg(OFS_CTRL, 8'h01);
    #1;
    chk("force", {en, vref}, 2'b11);
    wr_reg(OFS_CTRL, 8'h00);
    #1;
    chk("off", {en, vref}, 2'b00);
    sw_conv(4'h1, 2'b00, 1'b0, 12'h000);
    rd_reg(OFS_STATUS, lo);
    chk("first", lo, 8'h00);
    // codes 0 and 4095 at the ends of the bias loop
    for (int i = 0; i < 4; i++)
      sw_conv(4'h0, 2'(i), 1'b0, (i == 3) ? 12'hFFF : 12'h000);
    for (int i = 0; i < 16; i++)
      sw_conv(4'(i), 2'(nxt()), 1'b0, 12'(nxt()));
    sw_conv(4'h2, 2'b00, 1'b0, 12'h5A5);
    n0 = settle;
    sw_conv(4'h2, 2'b00, 1'b1, 12'h5A5);
    chk("extend", 16'(settle - n0), 16'(EXT));
    // slots given in falling order so the block must sort them
    base = 12'h3C3;
    wr_reg(OFS_AUTO_SEL, {CH_EXT_TWO, CH_SUPPLY});
    wr_reg(OFS_AUTO_CTRL, 8'h03);
    chq.delete();
    wr_reg(OFS_AUTO_PER, 8'h01);
    wait_sig(2, 3000);
    chk("tick", found, 1);
    wr_reg(OFS_SW_SELECT, {4'h8, CH_USB_BUS});
    wait_sig(1, 600);
    chk("adone0", found, 1);
    wait_sig(0, 600);
    chk("swirq", found, 1);
    wait_sig(1, 600);
    chk("adone1", found, 1);
    wr_reg(OFS_AUTO_PER, 8'h00);
    chk("order", {4'h0, chq[0], chq[1], chq[2]}, 16'h02A7);
    rd_reg(OFS_AUTO0_LO, lo);
    rd_reg(OFS_AUTO0_HI, hi);
    chk("auto0", {hi, lo}, code_of(CH_EXT_TWO));
    rd_reg(OFS_AUTO1_LO, lo);
    rd_reg(OFS_AUTO1_HI, hi);
    chk("auto1", {hi, lo}, code_of(CH_SUPPLY));
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    rd_reg(OFS_STATUS, lo);
    chk("status", lo, 8'h04);
    give_verdict();
  end
endmodule
